//--- hdl/pci_master_dac_read.sv
// pci master sequencer: 32-bit burst read with dual address cycle
// assumes local master and pci bus share i_clk; pci pins are
// resolved outside from the output enables
// Notes on behaviour
// RULE_01: two address phases give 64-bit addressing
// RULE_02: local master requests with address, command, length
// RULE_03: request bus one cycle after local request
// RULE_04: grant and idle bus start, grant local
// RULE_05: request plus grant go to address loading
// RULE_06: frame follows address loading; master drops request
// RULE_07: first phase drives low address, dac command
// RULE_08: local master gives upper address then
// RULE_09: first address phase loads beat counter
// RULE_10: release request after frame without local request
// RULE_11: second phase upper address, read command, transaction
// RULE_12: local master gives byte enables, holds ready
// RULE_13: local grant follows bus grant
// RULE_14: turnaround floats ad, drives enables, irdy
// RULE_15: frame stays asserted while beats remain
// RULE_16: target asserts trdy with first word
// RULE_17: irdy and trdy both low completes phase
// RULE_18: next clock outputs word, decrements counter
// RULE_19: trdy and ready give local strobe
// RULE_20: irdy held only while local ready held
// RULE_21: target keeps trdy and drives words
// RULE_22: local master holds ready while accepting
// RULE_23: last beat negates frame
// RULE_24: after last beat release, report normal
// RULE_25: dac command uses standard code
// RULE_26: counter decrements once per completed phase
`timescale 1ns/10ps
module pci_master_dac_read
    import pci_dac_pkg::*;
(
    input  wire logic                          i_clk,
    input  wire logic                          i_sys_rst,
    // pci side
    input  wire logic                          i_gnt_n,
    output logic                               o_req_n,
    input  wire logic                          i_frame_n,
    output logic                               o_frame_n,
    output logic                               o_frame_oe,
    input  wire logic                          i_irdy_n,
    output logic                               o_irdy_n,
    output logic                               o_irdy_oe,
    input  wire logic                          i_trdy_n,
    input  wire logic                          i_devsel_n,
    input  wire logic [pci_dac_pkg::AD_W-1:0]  i_ad,
    output logic      [pci_dac_pkg::AD_W-1:0]  o_ad,
    output logic                               o_ad_oe,
    output logic      [pci_dac_pkg::CBE_W-1:0] o_cbe_n,
    output logic                               o_cbe_oe,
    // local master side
    input  wire logic                          i_local_req_32,
    input  wire logic [pci_dac_pkg::AD_W-1:0]  i_local_addr_data_in,
    input  wire logic [pci_dac_pkg::CBE_W-1:0] i_local_byte_en_in,
    input  wire logic [pci_dac_pkg::BURST_W-1:0] i_burst_len_in,
    input  wire logic                          i_local_rd_ready_n,
    output logic                               o_local_grant,
    output logic      [pci_dac_pkg::STAT_W-1:0] o_local_xfer_state,
    output logic      [pci_dac_pkg::TERM_W-1:0] o_termination_kind,
    output logic      [pci_dac_pkg::BURST_W-1:0] o_beat_counter,
    output logic      [pci_dac_pkg::AD_W-1:0]  o_local_data_out,
    output logic                               o_local_xfer_strobe
);
    import pci_dac_pkg::*;

    // ***********************************************
    // declarations
    // ***********************************************
    seq_state_t         state_q;
    seq_state_t         state_d;
    logic               req_n_q;
    logic               frame_n_q;
    logic               frame_oe_q;
    logic               irdy_n_q;
    logic               irdy_oe_q;
    logic [AD_W-1:0]    ad_q;
    logic               ad_oe_q;
    logic [CBE_W-1:0]   cbe_q;
    logic               cbe_oe_q;
    logic               grant_q;
    logic [STAT_W-1:0]  xstate_q;
    logic [TERM_W-1:0]  term_q;
    logic [AD_W-1:0]    lo_addr_q;
    logic [CBE_W-1:0]   cmd_q;
    logic [BURST_W-1:0] len_q;
    logic [TMO_W-1:0]   tmo_q;
    logic               claimed_q;
    logic               bus_idle;
    logic               beat_done;
    logic               last_beat;
    logic               one_left;
    logic               abort;

    beat_if bif ();

    beat_tracker u_beat (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .bus       (bif)
    );

    // ***********************************************
    // phase decode
    // ***********************************************
    assign bus_idle  = i_frame_n && i_irdy_n;
    assign beat_done = (state_q == ST_DATA) && !irdy_n_q && !i_trdy_n; // RULE_17
    assign last_beat = beat_done && (bif.count <= BURST_ONE);
    // beats still to finish after the current edge
    assign one_left  = (bif.count - BURST_ONE) == BURST_ONE;
    assign abort     = (state_q == ST_DATA) && !claimed_q && i_devsel_n
                       && (tmo_q == DEVSEL_TMO_CYC);

    assign bif.load       = (state_q == ST_LOAD);
    assign bif.len        = len_q;
    assign bif.beat_done  = beat_done;
    assign bif.rd_ready_n = i_local_rd_ready_n;
    assign bif.ad_sample  = i_ad;

    // ***********************************************
    // sequence
    // ***********************************************
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: if (i_local_req_32) state_d = ST_REQ; // RULE_03
            ST_REQ:  if (!i_gnt_n && bus_idle) state_d = ST_GRANT; // RULE_04
            ST_GRANT: begin
                if (i_local_req_32 && !i_gnt_n) begin
                    state_d = ST_LOAD; // RULE_05
                end else if (i_gnt_n) begin
                    state_d = ST_REQ;
                end
            end
            ST_LOAD:    state_d = ST_ADDR_LO; // RULE_06
            ST_ADDR_LO: state_d = ST_ADDR_HI; // RULE_01
            ST_ADDR_HI: state_d = ST_DATA;
            ST_DATA:    if (last_beat || abort) state_d = ST_TERM;
            ST_TERM:    state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ***********************************************
    // bus request and local grant
    // ***********************************************
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            req_n_q <= 1'b1;
        end else if (state_q == ST_IDLE && i_local_req_32) begin
            req_n_q <= 1'b0; // RULE_03
        end else if (!frame_n_q && frame_oe_q && !i_local_req_32) begin
            req_n_q <= 1'b1; // RULE_10
        end else if (state_q == ST_TERM) begin
            req_n_q <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            grant_q <= 1'b0;
        end else if (state_q == ST_REQ) begin
            grant_q <= !i_gnt_n && bus_idle; // RULE_04
        end else if (state_q inside {ST_GRANT, ST_LOAD, ST_ADDR_LO, ST_ADDR_HI}) begin
            grant_q <= !i_gnt_n; // RULE_13
        end else begin
            grant_q <= 1'b0;
        end
    end

    // ***********************************************
    // request capture
    // ***********************************************
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            lo_addr_q <= AD_RST;
            cmd_q     <= CMD_DAC;
            len_q     <= BURST_RST;
        end else if (state_q == ST_GRANT && i_local_req_32 && !i_gnt_n) begin
            lo_addr_q <= i_local_addr_data_in; // RULE_05
            cmd_q     <= i_local_byte_en_in;
            len_q     <= (i_burst_len_in == BURST_RST) ? BURST_ONE : i_burst_len_in;
        end
    end

    // ***********************************************
    // frame and initiator ready
    // ***********************************************
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            frame_n_q  <= 1'b1;
            frame_oe_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_LOAD: begin
                    frame_n_q  <= 1'b0; // RULE_06
                    frame_oe_q <= 1'b1;
                end
                ST_ADDR_HI: begin
                    frame_n_q  <= (bif.count <= BURST_ONE); // RULE_23
                    frame_oe_q <= 1'b1;
                end
                ST_DATA: begin
                    if (last_beat || abort) begin
                        frame_n_q  <= 1'b1; // RULE_24
                        frame_oe_q <= 1'b0;
                    end else if (beat_done && one_left) begin
                        frame_n_q  <= 1'b1; // RULE_23
                    end else begin
                        frame_n_q  <= frame_n_q; // RULE_15
                    end
                end
                default: begin
                    frame_n_q  <= frame_n_q;
                    frame_oe_q <= frame_oe_q;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            irdy_n_q  <= 1'b1;
            irdy_oe_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_ADDR_LO: begin
                    irdy_n_q  <= 1'b1;
                    irdy_oe_q <= 1'b1;
                end
                ST_ADDR_HI: irdy_n_q <= i_local_rd_ready_n; // RULE_14
                ST_DATA: begin
                    if (last_beat || abort) begin
                        irdy_n_q  <= 1'b1; // RULE_24
                    end else begin
                        irdy_n_q  <= i_local_rd_ready_n; // RULE_20
                    end
                end
                ST_TERM: irdy_oe_q <= 1'b0;
                default: irdy_n_q  <= irdy_n_q;
            endcase
        end
    end

    // ***********************************************
    // address and command lines
    // ***********************************************
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ad_q    <= AD_RST;
            ad_oe_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_LOAD: begin
                    ad_q    <= lo_addr_q; // RULE_07
                    ad_oe_q <= 1'b1;
                end
                ST_ADDR_LO: ad_q    <= i_local_addr_data_in; // RULE_11
                ST_ADDR_HI: ad_oe_q <= 1'b0; // RULE_14
                default:    ad_oe_q <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cbe_q    <= CMD_DAC;
            cbe_oe_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_LOAD: begin
                    cbe_q    <= cmd_q; // RULE_25
                    cbe_oe_q <= 1'b1;
                end
                ST_ADDR_LO: cbe_q <= CMD_MEM_READ; // RULE_11
                ST_ADDR_HI: cbe_q <= i_local_byte_en_in; // RULE_14
                ST_DATA: begin
                    if (last_beat || abort) begin
                        cbe_oe_q <= 1'b0; // RULE_24
                    end else if (beat_done) begin
                        cbe_q    <= i_local_byte_en_in;
                    end
                end
                default: cbe_oe_q <= 1'b0;
            endcase
        end
    end

    // ***********************************************
    // target claim watchdog and local status
    // ***********************************************
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tmo_q     <= TMO_RST;
            claimed_q <= 1'b0;
        end else if (state_q == ST_ADDR_HI) begin
            tmo_q     <= TMO_RST;
            claimed_q <= 1'b0;
        end else if (state_q == ST_DATA) begin
            claimed_q <= claimed_q || !i_devsel_n;
            if (tmo_q != DEVSEL_TMO_CYC) begin
                tmo_q <= tmo_q + 3'h1;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            xstate_q <= XS_IDLE;
            term_q   <= TK_NONE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (i_local_req_32) begin
                        xstate_q <= XS_IDLE;
                        term_q   <= TK_NONE;
                    end
                end
                ST_GRANT:   if (i_local_req_32 && !i_gnt_n) xstate_q <= XS_ADDR_LOAD; // RULE_05
                ST_ADDR_LO: xstate_q <= XS_BUS_XFER; // RULE_11
                ST_DATA: begin
                    if (last_beat) begin
                        xstate_q <= XS_BUS_TERM; // RULE_24
                        term_q   <= TK_NORMAL;
                    end else if (abort) begin
                        xstate_q <= XS_BUS_TERM;
                        term_q   <= TK_MASTER_ABORT;
                    end
                end
                default: xstate_q <= xstate_q; // RULE_07
            endcase
        end
    end

    // ***********************************************
    // outputs
    // ***********************************************
    assign o_req_n             = req_n_q;
    assign o_frame_n           = frame_n_q;
    assign o_frame_oe          = frame_oe_q;
    assign o_irdy_n            = irdy_n_q;
    assign o_irdy_oe           = irdy_oe_q;
    assign o_ad                = ad_q;
    assign o_ad_oe             = ad_oe_q;
    assign o_cbe_n             = cbe_q;
    assign o_cbe_oe            = cbe_oe_q;
    assign o_local_grant       = grant_q;
    assign o_local_xfer_state  = xstate_q;
    assign o_termination_kind  = term_q;
    assign o_beat_counter      = bif.count;
    assign o_local_data_out    = bif.data;
    assign o_local_xfer_strobe = bif.strobe;

endmodule

//--- hdl/pci_dac_pkg.sv
// constants and types for the dual address cycle read sequencer
// assumes one clock domain, the pci clock, shared by local logic
package pci_dac_pkg;

    // ***********************************************
    // widths
    // ***********************************************
    localparam int unsigned AD_W    = 32;
    localparam int unsigned CBE_W   = 4;
    localparam int unsigned BURST_W = 8;
    localparam int unsigned STAT_W  = 4;
    localparam int unsigned TERM_W  = 2;
    localparam int unsigned TMO_W   = 3;

    // ***********************************************
    // bus commands
    // ***********************************************
    localparam logic [CBE_W-1:0] CMD_DAC      = 4'hD;
    localparam logic [CBE_W-1:0] CMD_MEM_READ = 4'h6;

    // ***********************************************
    // local status codes
    // ***********************************************
    localparam logic [STAT_W-1:0] XS_IDLE      = 4'h0;
    localparam logic [STAT_W-1:0] XS_ADDR_LOAD = 4'h1;
    localparam logic [STAT_W-1:0] XS_BUS_XFER  = 4'h2;
    localparam logic [STAT_W-1:0] XS_BUS_TERM  = 4'h3;

    localparam logic [TERM_W-1:0] TK_NONE         = 2'h0;
    localparam logic [TERM_W-1:0] TK_NORMAL       = 2'h1;
    localparam logic [TERM_W-1:0] TK_MASTER_ABORT = 2'h2;

    // ***********************************************
    // reset values and timing
    // ***********************************************
    localparam logic [AD_W-1:0]    AD_RST    = 32'h0000_0000;
    localparam logic [BURST_W-1:0] BURST_RST = 8'h00;
    localparam logic [BURST_W-1:0] BURST_ONE = 8'h01;
    localparam logic [TMO_W-1:0]   TMO_RST   = 3'h0;
    // clocks after the high address phase with no target claim
    localparam logic [TMO_W-1:0]   DEVSEL_TMO_CYC = 3'h5;

    typedef enum logic [7:0] {
        ST_IDLE    = 8'h01,
        ST_REQ     = 8'h02,
        ST_GRANT   = 8'h04,
        ST_LOAD    = 8'h08,
        ST_ADDR_LO = 8'h10,
        ST_ADDR_HI = 8'h20,
        ST_DATA    = 8'h40,
        ST_TERM    = 8'h80
    } seq_state_t;

endpackage

//--- hdl/beat_if.sv
// carrier between the sequencer and its beat tracker
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface beat_if;
    import pci_dac_pkg::*;

    logic                 load;
    logic [BURST_W-1:0]   len;
    logic                 beat_done;
    logic                 rd_ready_n;
    logic [AD_W-1:0]      ad_sample;
    logic [BURST_W-1:0]   count;
    logic [AD_W-1:0]      data;
    logic                 strobe;

    modport ctrl (
        output load, len, beat_done, rd_ready_n, ad_sample,
        input  count, data, strobe
    );
    modport tracker (
        input  load, len, beat_done, rd_ready_n, ad_sample,
        output count, data, strobe
    );
endinterface

//--- hdl/beat_tracker.sv
// beat counter, read data capture and local transfer strobe
// assumes beat_done is already qualified by the sequencer
`timescale 1ns/10ps
module beat_tracker
    import pci_dac_pkg::*;
(
    input  wire logic   i_clk,
    input  wire logic   i_sys_rst,
    beat_if.tracker     bus
);

    logic [BURST_W-1:0] count_q;
    logic [AD_W-1:0]    data_q;
    logic               strobe_q;

    // ***********************************************
    // beat counter
    // ***********************************************
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            count_q <= BURST_RST;
        end else if (bus.load) begin
            count_q <= bus.len; // RULE_09
        end else if (bus.beat_done && count_q != BURST_RST) begin
            count_q <= count_q - BURST_ONE; // RULE_26
        end
    end

    // ***********************************************
    // read data toward local master
    // ***********************************************
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            data_q <= AD_RST;
        end else if (bus.beat_done) begin
            data_q <= bus.ad_sample; // RULE_18
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= bus.beat_done && !bus.rd_ready_n; // RULE_19
        end
    end

    assign bus.count  = count_q;
    assign bus.data   = data_q;
    assign bus.strobe = strobe_q;

endmodule

//--- tb/pci_dac_asserts.sv
// port checks for the dual address read sequencer
// assumes binding into pci_master_dac_read, one clock domain
`timescale 1ns/10ps
module pci_dac_asserts
    import pci_dac_pkg::*;
(
    input logic               i_clk,
    input logic               i_sys_rst,
    input logic               i_gnt_n,
    input logic               i_trdy_n,
    input logic [AD_W-1:0]    i_ad,
    input logic               i_local_req_32,
    input logic [AD_W-1:0]    i_local_addr_data_in,
    input logic               i_local_rd_ready_n,
    input logic               o_req_n,
    input logic               o_frame_n,
    input logic               o_irdy_n,
    input logic [AD_W-1:0]    o_ad,
    input logic               o_ad_oe,
    input logic [CBE_W-1:0]   o_cbe_n,
    input logic               o_local_grant,
    input logic [STAT_W-1:0]  o_local_xfer_state,
    input logic [TERM_W-1:0]  o_termination_kind,
    input logic [BURST_W-1:0] o_beat_counter,
    input logic [AD_W-1:0]    o_local_data_out,
    input logic               o_local_xfer_strobe
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    a_req_on_local: assert property (
        o_local_xfer_state == XS_IDLE && i_local_req_32 && o_req_n |=> !o_req_n) else $error("no bus request");
    a_grant_follow: assert property (
        o_local_grant |-> $past(i_gnt_n) == 1'b0) else $error("grant without bus grant");
    a_frame_after_load: assert property (
        o_local_xfer_state == XS_ADDR_LOAD && o_frame_n |=> !o_frame_n) else $error("frame late");
    a_low_phase: assert property (
        $fell(o_frame_n) |-> o_cbe_n == CMD_DAC && o_local_xfer_state == XS_ADDR_LOAD) else $error("low phase");
    a_high_phase: assert property (
        $fell(o_frame_n) |=> o_ad == $past(i_local_addr_data_in) && o_cbe_n == CMD_MEM_READ
        && o_local_xfer_state == XS_BUS_XFER) else $error("high phase");
    a_req_release: assert property (
        !o_frame_n && !i_local_req_32 |=> o_req_n) else $error("request kept");
    a_irdy_ready: assert property (
        o_local_xfer_state == XS_BUS_XFER && !o_ad_oe |-> o_irdy_n == $past(i_local_rd_ready_n))
        else $error("irdy not following ready");
    a_frame_last: assert property (
        o_local_xfer_state == XS_BUS_XFER && !o_ad_oe |-> o_frame_n == (o_beat_counter == BURST_ONE))
        else $error("frame vs beats left");
    a_beat_capture: assert property (
        !o_irdy_n && !i_trdy_n && o_local_xfer_state == XS_BUS_XFER |=> o_local_data_out == $past(i_ad)
        && o_beat_counter == BURST_W'($past(o_beat_counter) - 1)) else $error("beat capture");
    a_strobe_cause: assert property (
        o_local_xfer_strobe == $past(!o_irdy_n && !i_trdy_n && !i_local_rd_ready_n)) else $error("strobe");
    a_normal_end: assert property (
        !o_irdy_n && !i_trdy_n && o_frame_n && o_local_xfer_state == XS_BUS_XFER |=> o_irdy_n
        && o_local_xfer_state == XS_BUS_TERM && o_termination_kind == TK_NORMAL) else $error("end");
endmodule

bind pci_master_dac_read pci_dac_asserts pci_dac_asserts_inst (.*);

//--- tb/pci_target_model.sv
// arbiter plus read target on the far side of the sequencer
// assumes pins resolved by the bench with idle pull-ups
`timescale 1ns/10ps
module pci_target_model
    import pci_dac_pkg::*;
#(
    parameter logic [AD_W-1:0] BASE = 32'h0000_0000
)(
    input  logic            i_clk,
    input  logic            i_sys_rst,
    input  logic            i_req_n,
    input  logic            i_frame_n,
    input  logic            i_irdy_n,
    input  logic            i_host_drv,
    input  logic            i_stall,
    output logic            o_gnt_n,
    output logic            o_trdy_n,
    output logic            o_devsel_n,
    output logic [AD_W-1:0] o_ad
);
    logic [AD_W-1:0] word_q;
    wire             beat = !o_trdy_n && !i_irdy_n;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_gnt_n <= 1'b1;
        end else begin
            o_gnt_n <= i_req_n;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_trdy_n <= 1'b1;
            o_devsel_n <= 1'b1;
            word_q <= BASE;
        end else begin
            if (beat) word_q <= word_q + 1;
            if (beat && i_frame_n) begin
                o_trdy_n <= 1'b1;
                o_devsel_n <= 1'b1;
            end else if (!i_frame_n || !o_devsel_n) begin
                o_devsel_n <= 1'b0;
                o_trdy_n <= i_stall || i_host_drv;
            end
        end
    end

    // words not offered show inverted
    assign o_ad = o_trdy_n ? ~word_q : word_q;
endmodule

//--- tb/pci_master_dac_read_tb_top.sv
// bench for the dual address read sequencer
// assumes the target model and the bound port checker
`timescale 1ns/10ps
module pci_master_dac_read_tb_top;
    import pci_dac_pkg::*;
    localparam logic [AD_W-1:0] BASE = 32'hC0DE_0100;
    logic i_clk = 0, i_sys_rst = 1, req = 0, rdy_n = 1, stall = 0, slow = 0;
    logic gnt_n, req_n, frame_n, frame_oe, irdy_n, irdy_oe, trdy_n, devsel_n, ad_oe, cbe_oe, grant, strobe;
    logic [AD_W-1:0] lad = '0, tad, o_ad, dout, exp_w = BASE;
    logic [CBE_W-1:0] lbe = '0, cbe;
    logic [BURST_W-1:0] blen = '0, cnt;
    logic [STAT_W-1:0] xs;
    logic [TERM_W-1:0] tk;
    int num_errors = 0, checked = 0;
    wire f_n = frame_oe ? frame_n : 1'b1;
    wire i_n = irdy_oe ? irdy_n : 1'b1;
    wire [AD_W-1:0] ad = ad_oe ? o_ad : tad;

    pci_master_dac_read pci_master_dac_read_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_gnt_n(gnt_n),
        .o_req_n(req_n), .i_frame_n(f_n), .o_frame_n(frame_n), .o_frame_oe(frame_oe), .i_irdy_n(i_n),
        .o_irdy_n(irdy_n), .o_irdy_oe(irdy_oe), .i_trdy_n(trdy_n), .i_devsel_n(devsel_n), .i_ad(ad),
        .o_ad(o_ad), .o_ad_oe(ad_oe), .o_cbe_n(cbe), .o_cbe_oe(cbe_oe), .i_local_req_32(req),
        .i_local_addr_data_in(lad), .i_local_byte_en_in(lbe), .i_burst_len_in(blen),
        .i_local_rd_ready_n(rdy_n), .o_local_grant(grant), .o_local_xfer_state(xs),
        .o_termination_kind(tk), .o_beat_counter(cnt), .o_local_data_out(dout), .o_local_xfer_strobe(strobe));
    pci_target_model #(.BASE(BASE)) pci_target_model_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_req_n(req_n), .i_frame_n(f_n), .i_irdy_n(i_n), .i_host_drv(ad_oe), .i_stall(stall),
        .o_gnt_n(gnt_n), .o_trdy_n(trdy_n), .o_devsel_n(devsel_n), .o_ad(tad));

    always #2 i_clk = ~i_clk;
    always @(posedge i_clk) stall <= #1 slow & ~stall;

    task automatic tick();
        @(posedge i_clk);
        #1;
    endtask

    task automatic chk(input bit ok, input string m);
        checked++;
        if (!ok) begin
            num_errors++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask

    task automatic run_burst(input logic [BURST_W-1:0] len, input logic [AD_W-1:0] lo, hi, input int late);
        int t = 0, n = 0;
        req = 1;
        lad = lo;
        lbe = CMD_DAC;
        blen = len;
        while (f_n !== 1'b0 && t < 40) begin
            tick();
            t++;
            if (xs === XS_ADDR_LOAD) req = 0;
        end
        chk(ad === lo && cbe === CMD_DAC, "low address phase");
        lad = hi;
        tick();
        chk(ad === hi && cbe === CMD_MEM_READ && xs === XS_BUS_XFER, "high address phase");
        lbe = 4'h0;
        repeat (late) tick();
        rdy_n = 0;
        while (xs !== XS_BUS_TERM && t < 80) begin
            tick();
            t++;
            if (strobe === 1'b1) begin
                chk(dout === exp_w, "read word");
                exp_w++;
                n++;
            end
        end
        chk(BURST_W'(n) === len && cnt === BURST_RST && tk === TK_NORMAL, "burst end");
        rdy_n = 1;
        tick();
        chk(xs === XS_BUS_TERM && irdy_oe === 1'b0 && req_n === 1'b1, "bus released");
    endtask

    task automatic test_bursts();
        run_burst(8'h01, 32'h1000_0040, 32'h0000_0002, 0);
        run_burst(8'h04, 32'h2000_0000, 32'hFFFF_FFFF, 0);
        run_burst(8'h02, 32'h0000_0100, 32'h8000_0000, 0);
        slow = 1;
        run_burst(8'h03, 32'h3000_0010, 32'h0000_0001, 3);
        slow = 0;
    endtask

    task automatic test_reset();
        req = 1;
        lbe = CMD_DAC;
        blen = 8'h08;
        repeat (9) tick();
        i_sys_rst = 1;
        req = 0;
        tick();
        chk(req_n === 1'b1 && frame_oe === 1'b0 && irdy_oe === 1'b0 && ad_oe === 1'b0 && xs === XS_IDLE
            && strobe === 1'b0 && cnt === BURST_RST, "reset values");
        i_sys_rst = 0;
        exp_w = BASE;
        tick();
        run_burst(8'h02, 32'h4000_0000, 32'h0000_0003, 0);
    endtask

    task automatic stop_test();
        $display("checked=%0d num_errors=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge i_clk);
        #1;
        i_sys_rst = 0;
        tick();
        test_bursts();
        test_reset();
        stop_test();
    end

    initial begin
        #40000;
        num_errors++;
        stop_test();
    end
endmodule
